// ===== design/scw_pkg.sv
`default_nettype none
package scw_pkg;
  // ***************************************************
  // control word placement on the byte port
  // ***************************************************
  localparam logic [5:0] CW_ADDR_FIRST = 6'h1d;
  localparam logic [5:0] CW_ADDR_LAST = 6'h20;
  localparam logic [1:0] LANE_LAST = 2'h3;
  localparam logic [31:0] CW_RESET = 32'h0060_0000;
  localparam logic [31:0] CW_READ_MASK = 32'h1fff_7fff;
  localparam logic [31:0] HOST_FORCE_ZERO = 32'he880_0000;
  localparam logic [31:0] CW_ONE_SHOT = 32'h0000_8000;
  // ***************************************************
  // bit positions of the control word
  // ***************************************************
  localparam int BIT_COMP_PD = 28;
  localparam int BIT_HALT = 27;
  localparam int BIT_CDAC_PD = 26;
  localparam int BIT_FULL_PD = 25;
  localparam int BIT_DIG_PD = 24;
  localparam int BIT_PLL_RANGE = 22;
  localparam int BIT_PLL_BYPASS = 21;
  localparam int FACTOR_MSB = 20;
  localparam int FACTOR_LSB = 16;
  localparam int BIT_ACC1_CLR = 15;
  localparam int BIT_ACC_HOLD = 14;
  localparam int BIT_TRIANGLE = 13;
  localparam int MODE_MSB = 11;
  localparam int MODE_LSB = 9;
  localparam logic [4:0] FACTOR_MIN = 5'h04;
  localparam logic [4:0] FACTOR_MAX = 5'h14;
  // ***************************************************
  // operating modes
  // ***************************************************
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'h0,
    MODE_FSK = 3'h1,
    MODE_RAMPED_FSK = 3'h2,
    MODE_CHIRP = 3'h3,
    MODE_BPSK = 3'h4
  } scw_mode_e;
  // ***************************************************
  // controller registers (avalon word addresses)
  // ***************************************************
  localparam logic [1:0] AV_CMD_WORD = 2'h0;
  localparam logic [1:0] AV_CTRL = 2'h1;
  localparam logic [1:0] AV_STATUS = 2'h2;
  localparam logic [1:0] AV_READBACK = 2'h3;
  localparam int CTRL_GO_WRITE = 0;
  localparam int CTRL_GO_READ = 1;
  localparam int CTRL_CLR_REJECT = 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WRITE = 3'b001,
    ST_UPDATE = 3'b011,
    ST_READ = 3'b010,
    ST_READ_WAIT = 3'b110,
    ST_READ_TAKE = 3'b100
  } scw_host_state_e;
endpackage
`default_nettype wire

// ===== design/scw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scw_link_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic config_update_strobe;
  modport device(input addr, input wdata, input wr, input rd, input config_update_strobe,
                 output rdata);
  modport host(output addr, output wdata, output wr, output rd, output config_update_strobe,
               input rdata);
endinterface
`default_nettype wire

// ===== design/scw_cw_lane.sv
`timescale 1ns/1ps
`default_nettype none
module scw_cw_lane #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // byte write and self-clear
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] clr_mask,
  // stored byte
  output logic [7:0] q
);
  logic [7:0] byte_q;
  logic [7:0] byte_d;

  // write wins over a self-clear landing in the same cycle
  always_comb begin
    byte_d = byte_q & ~clr_mask;
    if (wr_en) begin
      byte_d = wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      byte_q <= RESET_VAL;
    end else if (ce) begin
      byte_q <= byte_d;
    end
  end

  assign q = byte_q;
endmodule
`default_nettype wire

// ===== design/scw_device.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 32-bit word at bytes 1d..20, MSB first
// - host writes zero to bit 23
// - bit 27 set halts until master reset
// - bit 28 powers down comparator
// - bit 26 powers down control DAC only
// - bit 25 powers down both DACs, reference
// - bit 24 gates digital clocks, multiplier runs
// - bit 22 oscillator gain, resets to one
// - bit 21 bypasses multiplier, resets to one
// - bits 20:16 factor, range 4..20
// - bit 15 one-shot accumulator one clear
// - one-shot clear acts in every mode
// - bit 14 holds both accumulators zero
// - bit 13 triangle sweep, ramped FSK
// - mode field bits 11:9 encoding
// - new values apply only on update
module scw_device (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // programming port
  scw_link_if.device link,
  // analog power-down indications
  output logic comparator_pd,
  output logic control_dac_pd,
  output logic cosine_dac_pd,
  output logic reference_pd,
  // digital section and clock multiplier
  output logic digital_clock_gate,
  output logic pll_high_gain,
  output logic pll_bypass,
  output logic [4:0] pll_factor,
  output logic pll_factor_ok,
  // accumulators and sweep
  output logic acc1_clear_pulse,
  output logic acc_hold_clear,
  output logic triangle_sweep,
  output logic sweep_mode_ok,
  output var scw_pkg::scw_mode_e op_mode,
  // whole active word and halt
  output logic [31:0] active_word,
  output logic halted
);
  // ***************************************************
  // decode helpers
  // ***************************************************
  function automatic logic addr_hit(input logic [5:0] a);
    addr_hit = (a >= scw_pkg::CW_ADDR_FIRST) && (a <= scw_pkg::CW_ADDR_LAST);
  endfunction

  function automatic logic [1:0] lane_of(input logic [5:0] a);
    logic [5:0] off;
    off = a - scw_pkg::CW_ADDR_FIRST;
    lane_of = off[1:0];
  endfunction

  function automatic logic factor_in_range(input logic [4:0] f);
    factor_in_range = (f >= scw_pkg::FACTOR_MIN) && (f <= scw_pkg::FACTOR_MAX);
  endfunction

  // ***************************************************
  // pending word, one lane per byte address
  // ***************************************************
  logic [31:0] pend;
  logic [31:0] clr_bits;
  logic halted_q;
  logic upd_take;

  // a taken update retires the one-shot bit so it never fires twice
  assign upd_take = link.config_update_strobe && !halted_q;
  assign clr_bits = upd_take ? scw_pkg::CW_ONE_SHOT : 32'h0000_0000;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      localparam int HI = 31 - 8 * gi;
      logic lane_wr;
      // halted device accepts no writes; bytes land MSB first
      assign lane_wr = link.wr && !halted_q && addr_hit(link.addr)
                       && (lane_of(link.addr) == 2'(gi));
      scw_cw_lane #(
        .RESET_VAL(scw_pkg::CW_RESET[HI -: 8])
      ) u_lane (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(lane_wr),
        .wdata(link.wdata),
        .clr_mask(clr_bits[HI -: 8]),
        .q(pend[HI -: 8])
      );
    end
  endgenerate

  // ***************************************************
  // read-back path
  // ***************************************************
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [31:0] pend_view;

  // bits 31:29 and the one-shot bit 15 never read back as one
  assign pend_view = pend & scw_pkg::CW_READ_MASK;

  // unmapped or halted reads answer zero
  always_comb begin
    rdata_d = 8'h00;
    if (link.rd && !halted_q && addr_hit(link.addr)) begin
      rdata_d = pend_view[8'(31 - 8 * int'(lane_of(link.addr))) -: 8];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  assign link.rdata = rdata_q;

  // ***************************************************
  // active word and decoded outputs
  // ***************************************************
  logic [31:0] act_q;
  logic [31:0] act_d;
  logic halted_d;
  logic comp_pd_q, comp_pd_d;
  logic cdac_pd_q, cdac_pd_d;
  logic cos_pd_q, cos_pd_d;
  logic ref_pd_q, ref_pd_d;
  logic dig_gate_q, dig_gate_d;
  logic gain_q, gain_d;
  logic bypass_q, bypass_d;
  logic [4:0] factor_q, factor_d;
  logic factor_ok_q, factor_ok_d;
  logic acc1_q, acc1_d;
  logic hold_q, hold_d;
  logic tri_q, tri_d;
  logic tri_ok_q, tri_ok_d;
  scw_pkg::scw_mode_e mode_q, mode_d;

  // next active state; all derived outputs follow the new word together
  always_comb begin
    act_d = act_q;
    halted_d = halted_q;
    acc1_d = 1'b0;
    if (upd_take) begin
      act_d = pend & ~scw_pkg::CW_ONE_SHOT;
      acc1_d = pend[scw_pkg::BIT_ACC1_CLR];
      halted_d = pend[scw_pkg::BIT_HALT];
    end
    comp_pd_d = act_d[scw_pkg::BIT_COMP_PD];
    cdac_pd_d = act_d[scw_pkg::BIT_CDAC_PD] || act_d[scw_pkg::BIT_FULL_PD];
    cos_pd_d = act_d[scw_pkg::BIT_FULL_PD];
    ref_pd_d = act_d[scw_pkg::BIT_FULL_PD];
    // halt also stops the digital clocks; multiplier keeps running
    dig_gate_d = act_d[scw_pkg::BIT_DIG_PD] || halted_d;
    gain_d = act_d[scw_pkg::BIT_PLL_RANGE];
    bypass_d = act_d[scw_pkg::BIT_PLL_BYPASS];
    factor_d = act_d[scw_pkg::FACTOR_MSB:scw_pkg::FACTOR_LSB];
    // factor only matters while the multiplier is in use
    factor_ok_d = bypass_d || factor_in_range(factor_d);
    hold_d = act_d[scw_pkg::BIT_ACC_HOLD];
    tri_d = act_d[scw_pkg::BIT_TRIANGLE];
    mode_d = scw_pkg::scw_mode_e'(act_d[scw_pkg::MODE_MSB:scw_pkg::MODE_LSB]);
    tri_ok_d = !tri_d || (mode_d == scw_pkg::MODE_RAMPED_FSK);
  end

  // power-up word sets gain and bypass; halt only leaves on rst_n
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= scw_pkg::CW_RESET;
      halted_q <= 1'b0;
      comp_pd_q <= 1'b0;
      cdac_pd_q <= 1'b0;
      cos_pd_q <= 1'b0;
      ref_pd_q <= 1'b0;
      dig_gate_q <= 1'b0;
      gain_q <= 1'b1;
      bypass_q <= 1'b1;
      factor_q <= 5'h00;
      factor_ok_q <= 1'b1;
      acc1_q <= 1'b0;
      hold_q <= 1'b0;
      tri_q <= 1'b0;
      tri_ok_q <= 1'b1;
      mode_q <= scw_pkg::MODE_SINGLE;
    end else if (ce) begin
      act_q <= act_d;
      halted_q <= halted_d;
      comp_pd_q <= comp_pd_d;
      cdac_pd_q <= cdac_pd_d;
      cos_pd_q <= cos_pd_d;
      ref_pd_q <= ref_pd_d;
      dig_gate_q <= dig_gate_d;
      gain_q <= gain_d;
      bypass_q <= bypass_d;
      factor_q <= factor_d;
      factor_ok_q <= factor_ok_d;
      acc1_q <= acc1_d;
      hold_q <= hold_d;
      tri_q <= tri_d;
      tri_ok_q <= tri_ok_d;
      mode_q <= mode_d;
    end
  end

  // outputs straight from the registers
  assign comparator_pd = comp_pd_q;
  assign control_dac_pd = cdac_pd_q;
  assign cosine_dac_pd = cos_pd_q;
  assign reference_pd = ref_pd_q;
  assign digital_clock_gate = dig_gate_q;
  assign pll_high_gain = gain_q;
  assign pll_bypass = bypass_q;
  assign pll_factor = factor_q;
  assign pll_factor_ok = factor_ok_q;
  assign acc1_clear_pulse = acc1_q;
  assign acc_hold_clear = hold_q;
  assign triangle_sweep = tri_q;
  assign sweep_mode_ok = tri_ok_q;
  assign op_mode = mode_q;
  assign active_word = act_q;
  assign halted = halted_q;
endmodule
`default_nettype wire

// ===== design/scw_host.sv
`timescale 1ns/1ps
`default_nettype none
module scw_host (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // programming port
  scw_link_if.host link
);
  // ***************************************************
  // avalon slave: one wait cycle, then answer
  // ***************************************************
  localparam int BYTE_W = 8;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] cmd_q, cmd_d;
  logic [31:0] rback_q, rback_d;
  logic rej_q, rej_d;
  logic busy;
  logic commit;
  logic ctrl_hit;
  logic go_write;
  logic go_read;
  scw_pkg::scw_host_state_e state_q, state_d;
  logic [1:0] lane_q, lane_d;
  logic [5:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;
  logic strobe_q, strobe_d;

  // byte of a word by lane, lane zero holding the top byte
  function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] lane);
    lane_byte = 8'(w >> (BYTE_W * int'(scw_pkg::LANE_LAST - lane)));
  endfunction

  // replace one lane of a word
  function automatic logic [31:0] lane_put(input logic [31:0] w, input logic [1:0] lane,
                                           input logic [7:0] b);
    int sh;
    sh = BYTE_W * int'(scw_pkg::LANE_LAST - lane);
    lane_put = (w & ~(32'h0000_00ff << sh)) | (32'(b) << sh);
  endfunction

  // a request is answered on its second cycle
  assign busy = (state_q != scw_pkg::ST_IDLE);
  assign commit = avs_write && !wait_q;
  assign ctrl_hit = commit && (avs_address == scw_pkg::AV_CTRL);
  assign go_write = ctrl_hit && avs_writedata[scw_pkg::CTRL_GO_WRITE] && !busy;
  assign go_read = ctrl_hit && avs_writedata[scw_pkg::CTRL_GO_READ] && !busy;

  // read data is latched in the wait cycle so it stands at the accepting edge
  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    cmd_d = cmd_q;
    rej_d = rej_q;
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
    end
    if (avs_read && wait_q) begin
      if (avs_address == scw_pkg::AV_CMD_WORD) begin
        rdata_d = cmd_q;
      end else if (avs_address == scw_pkg::AV_STATUS) begin
        rdata_d = {30'h0, rej_q, busy};
      end else if (avs_address == scw_pkg::AV_READBACK) begin
        rdata_d = rback_q;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
    if (ctrl_hit && avs_writedata[scw_pkg::CTRL_CLR_REJECT]) begin
      rej_d = 1'b0;
    end
    // the word may not move under a running transfer; refusal wins over clear
    if (commit && (avs_address == scw_pkg::AV_CMD_WORD)) begin
      if (busy) begin
        rej_d = 1'b1;
      end else begin
        cmd_d = avs_writedata & ~scw_pkg::HOST_FORCE_ZERO;
      end
    end
    if (ctrl_hit && busy && (avs_writedata[scw_pkg::CTRL_GO_WRITE]
                             || avs_writedata[scw_pkg::CTRL_GO_READ])) begin
      rej_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      cmd_q <= 32'h0000_0000;
      rej_q <= 1'b0;
    end else if (ce) begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      cmd_q <= cmd_d;
      rej_q <= rej_d;
    end
  end

  // ***************************************************
  // link sequencer: four bytes, then one update strobe
  // ***************************************************
  // link outputs are registered, so each lags its state by one cycle
  always_comb begin
    state_d = state_q;
    lane_d = lane_q;
    rback_d = rback_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    strobe_d = 1'b0;
    case (state_q)
      scw_pkg::ST_IDLE: begin
        lane_d = 2'h0;
        if (go_write) begin
          state_d = scw_pkg::ST_WRITE;
        end else if (go_read) begin
          state_d = scw_pkg::ST_READ;
        end
      end
      scw_pkg::ST_WRITE: begin
        wr_d = 1'b1;
        addr_d = scw_pkg::CW_ADDR_FIRST + 6'(lane_q);
        wdata_d = lane_byte(cmd_q, lane_q);
        lane_d = lane_q + 2'h1;
        if (lane_q == scw_pkg::LANE_LAST) begin
          state_d = scw_pkg::ST_UPDATE;
        end
      end
      scw_pkg::ST_UPDATE: begin
        // strobe only once the last byte has landed
        strobe_d = 1'b1;
        state_d = scw_pkg::ST_IDLE;
      end
      scw_pkg::ST_READ: begin
        rd_d = 1'b1;
        addr_d = scw_pkg::CW_ADDR_FIRST + 6'(lane_q);
        state_d = scw_pkg::ST_READ_WAIT;
      end
      scw_pkg::ST_READ_WAIT: begin
        state_d = scw_pkg::ST_READ_TAKE;
      end
      scw_pkg::ST_READ_TAKE: begin
        // device answer is registered, so it stands two cycles after the state
        rback_d = lane_put(rback_q, lane_q, link.rdata);
        lane_d = lane_q + 2'h1;
        if (lane_q == scw_pkg::LANE_LAST) begin
          state_d = scw_pkg::ST_IDLE;
        end else begin
          state_d = scw_pkg::ST_READ;
        end
      end
      default: begin
        state_d = scw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= scw_pkg::ST_IDLE;
      lane_q <= 2'h0;
      rback_q <= 32'h0000_0000;
      addr_q <= 6'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      strobe_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      lane_q <= lane_d;
      rback_q <= rback_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      strobe_q <= strobe_d;
    end
  end

  // outputs straight from the registers
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.wr = wr_q;
  assign link.rd = rd_q;
  assign link.config_update_strobe = strobe_q;
endmodule
`default_nettype wire

// ===== verif/scw_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module scw_link_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link and device outputs
  input wire logic config_update_strobe,
  input wire logic [31:0] active_word,
  input wire logic comparator_pd,
  input wire logic control_dac_pd,
  input wire logic cosine_dac_pd,
  input wire logic reference_pd,
  input wire logic digital_clock_gate,
  input wire logic [4:0] pll_factor,
  input wire logic pll_factor_ok,
  input wire logic acc1_clear_pulse,
  input wire logic halted
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ****
  // properties
  // ****
  // one-shot bit excluded: the active word always holds it at zero
  a_update_gates_word: assert property (
    $changed(active_word & ~scw_pkg::CW_ONE_SHOT) |->
    $past(config_update_strobe) || $past(config_update_strobe, 2)) else $error("word moved early");
  a_comp_pd_follow: assert property (
    comparator_pd == active_word[28]) else $error("comparator pd wrong");
  a_cdac_pd_follow: assert property (
    control_dac_pd == (active_word[26] | active_word[25])) else $error("control dac pd wrong");
  a_full_pd_follow: assert property (
    cosine_dac_pd == active_word[25] && reference_pd == active_word[25]) else $error("full pd wrong");
  a_dig_gate_follow: assert property (
    digital_clock_gate == (active_word[24] | halted)) else $error("digital gate wrong");
  a_factor_range: assert property (
    pll_factor == active_word[20:16] &&
    pll_factor_ok == (active_word[21] || (pll_factor >= 5'h04 && pll_factor <= 5'h14)))
    else $error("factor wrong");
  a_pulse_single: assert property (
    acc1_clear_pulse |=> !acc1_clear_pulse) else $error("clear pulse too long");
  a_never_halted: assert property (
    !halted) else $error("device halted");
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, active_word, rd_q;
  logic avs_waitrequest, comparator_pd, control_dac_pd, cosine_dac_pd, reference_pd;
  logic digital_clock_gate, pll_high_gain, pll_bypass, pll_factor_ok, acc1_clear_pulse;
  logic acc_hold_clear, triangle_sweep, sweep_mode_ok, halted;
  logic [4:0] pll_factor;
  scw_pkg::scw_mode_e op_mode;
  int err_count = 0;
  int samples_checked = 0;
  int pulses = 0;
  logic [31:0] words [7] = '{32'h1014_4000, 32'h0443_0200, 32'h0224_2400,
    32'h0115_0600, 32'h0000_0800, 32'he880_0000, 32'h0023_2000};
  // ****
  // clock, parts and checker
  // ****
  always #4 clk_sys = ~clk_sys;
  scw_link_if link_bus ();
  scw_host i_scw_host (.clk_sys, .rst_n, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .link(link_bus.host));
  scw_device i_scw_device (.clk_sys, .rst_n, .ce(1'b1), .link(link_bus.device),
    .comparator_pd, .control_dac_pd, .cosine_dac_pd, .reference_pd, .digital_clock_gate,
    .pll_high_gain, .pll_bypass, .pll_factor, .pll_factor_ok, .acc1_clear_pulse,
    .acc_hold_clear, .triangle_sweep, .sweep_mode_ok, .op_mode, .active_word, .halted);
  scw_link_checker i_chk (.clk_sys, .rst_n, .config_update_strobe(link_bus.config_update_strobe),
    .active_word, .comparator_pd, .control_dac_pd, .cosine_dac_pd, .reference_pd,
    .digital_clock_gate, .pll_factor, .pll_factor_ok, .acc1_clear_pulse, .halted);
  // count one-shot pulses seen by the accumulator
  always @(posedge clk_sys) if (acc1_clear_pulse === 1'b1) pulses <= pulses + 1;
  // ****
  // tasks
  // ****
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one edge idle first so no signal is assigned twice in a time step
  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // wait for link activity of one kind, then for it to settle
  task automatic wait_link(input logic upd);
    int n;
    int q;
    q = 0;
    for (n = 0; n < 400 && q < 6; n++) begin
      @(posedge clk_sys);
      q = ((upd ? link_bus.config_update_strobe : link_bus.rd) === 1'b1) ? 1 : (q > 0 ? q + 1 : 0);
    end
    chk("link done", 32'h6, q);
  endtask
  task automatic t_prog(input logic [31:0] w);
    logic [31:0] e;
    logic [31:0] p;
    e = w & ~scw_pkg::HOST_FORCE_ZERO;
    p = active_word;
    av(1'b1, scw_pkg::AV_CMD_WORD, w);
    repeat (4) @(posedge clk_sys);
    chk("held", p & scw_pkg::CW_READ_MASK, active_word & scw_pkg::CW_READ_MASK);
    av(1'b1, scw_pkg::AV_CTRL, 32'h1 << scw_pkg::CTRL_GO_WRITE);
    wait_link(1'b1);
    chk("word", e & scw_pkg::CW_READ_MASK, active_word & scw_pkg::CW_READ_MASK);
    chk("pd", {e[28], e[26] | e[25], e[25], e[25]}, {comparator_pd, control_dac_pd,
      cosine_dac_pd, reference_pd});
    chk("clk", {e[24], e[22:16], 1'(e[21] || (e[20:16] >= scw_pkg::FACTOR_MIN &&
      e[20:16] <= scw_pkg::FACTOR_MAX))}, {digital_clock_gate, pll_high_gain, pll_bypass,
      pll_factor, pll_factor_ok});
    chk("acc", {e[14:13], e[11:9], 1'(!e[13] || e[11:9] == scw_pkg::MODE_RAMPED_FSK)},
      {acc_hold_clear, triangle_sweep, op_mode, sweep_mode_ok});
    av(1'b1, scw_pkg::AV_CTRL, 32'h1 << scw_pkg::CTRL_GO_READ);
    wait_link(1'b0);
    av(1'b0, scw_pkg::AV_READBACK, 32'h0);
    chk("readback", e & scw_pkg::CW_READ_MASK, rd_q);
  endtask
  task automatic t_pulse(input logic [31:0] w);
    pulses = 0;
    t_prog(w);
    chk("pulses", 32'h1, pulses);
  endtask
  // a start while the link is busy is refused and flagged until cleared
  task automatic t_busy(input logic [31:0] w);
    logic [31:0] e;
    e = w & ~scw_pkg::HOST_FORCE_ZERO;
    av(1'b1, scw_pkg::AV_CMD_WORD, w);
    av(1'b0, scw_pkg::AV_CMD_WORD, 32'h0);
    chk("cmd", e, rd_q);
    av(1'b1, scw_pkg::AV_CTRL, 32'h1 << scw_pkg::CTRL_GO_WRITE);
    av(1'b1, scw_pkg::AV_CTRL, 32'h1 << scw_pkg::CTRL_GO_READ);
    wait_link(1'b1);
    chk("busy word", e & scw_pkg::CW_READ_MASK, active_word & scw_pkg::CW_READ_MASK);
    av(1'b0, scw_pkg::AV_STATUS, 32'h0);
    chk("refused", 32'h2, rd_q);
    av(1'b1, scw_pkg::AV_CTRL, 32'h1 << scw_pkg::CTRL_CLR_REJECT);
    av(1'b0, scw_pkg::AV_STATUS, 32'h0);
    chk("cleared", 32'h0, rd_q);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****
  // main sequence and watchdog
  // ****
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("reset word", scw_pkg::CW_RESET, active_word & scw_pkg::CW_READ_MASK);
    foreach (words[i]) t_prog(words[i]);
    t_pulse(32'h0000_8600);
    t_pulse(32'h0000_8000);
    t_busy(32'h0cc3_0200);
    chk("halted", 32'h0, halted);
    final_report();
  end
  // each programming pass takes well under two thousand cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
